// ===== hw/hotswap_fault_led_control.sv
// Fault logging, force-on override and LED/GPIO register bank.
// Assumes a serial front end presenting byte reads and writes, one cycle each.
// Operation
// - Unlocked force-on holds channel enabled
// - Forced on: faults never shut down
// - Logging and alert continue while forced
// - Override needs key 0xA5
// - Each comparator event sets own bit
// - Warning at bit 0, critical bit 4
// - Overcurrent warning single flag
// - Breaker log: slow and fast flags
// - Breaker fault is OR of flags
// - Logs latch until read or restart; breaker log until restart
// - Breaker trip shutdown drives fault low
// - Voltage shutdowns leave fault released
// - Disable releases fault output
// - Any log bit drives alert low
// - Alert mirrored in general status
// - Off bit releases driver, else sinks
// - Flash toggles at 1 Hz, overriding off
// - Phase bits pick flash polarity
// - Low bits enable weak pull-up
// - Disabled LEDs read back as inputs
`timescale 1ns/1ns
`include "hotswap_fault_consts.svh"
module hotswap_fault_led_control #(
    parameter int unsigned NUM_LEDS = 4,
    parameter int unsigned FLASH_HALF_CYCLES = `FLASH_HALF_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire hotswap_fault_pkg::reg_byte_t reg_addr,
    input wire hotswap_fault_pkg::reg_byte_t reg_wdata,
    output hotswap_fault_pkg::reg_byte_t reg_rdata,
    // Channel enable sources
    input wire logic channel_on_pin,
    input wire logic channel_enable_first,
    input wire logic channel_enable_second,
    // Comparator hits
    input wire logic uv_warn_hit,
    input wire logic uv_crit_hit,
    input wire logic ov_warn_hit,
    input wire logic ov_crit_hit,
    input wire logic oc_warn_hit,
    // Breaker trips
    input wire logic slow_trip_hit,
    input wire logic fast_trip_hit,
    // Shutdown policy: critical voltage compares shut the channel down
    input wire logic crit_shutdown_en,
    // Channel control out
    output logic channel_enable,
    output logic fault_n_o,
    output logic fault_n_oe,
    output logic alert_n_o,
    output logic alert_n_oe,
    // LED / GPIO pins
    input wire logic [NUM_LEDS-1:0] led_i,
    output logic [NUM_LEDS-1:0] led_o,
    output logic [NUM_LEDS-1:0] led_oe,
    output logic [NUM_LEDS-1:0] led_pullup_en
);
    import hotswap_fault_pkg::*;

    // Register field widths fit one byte
    initial begin
        if (NUM_LEDS != 4) begin
            $error("hotswap_fault_led_control: NUM_LEDS must be 4");
        end
    end

    // All block state
    typedef struct packed {
        logic [7:0] breaker_event_log;
        logic [7:0] undervoltage_event_status;
        logic [7:0] overvoltage_event_status;
        logic [7:0] overcurrent_warning_status;
        logic [7:0] force_on_unlock_key;
        logic override_bit;
        logic [7:0] led_drive_flash_control;
        logic [7:0] led_phase_pullup_control;
        logic [3:0] pin_level_readback;
        logic latched_off;
        logic breaker_shutdown;
        logic enable_seen;
        logic [7:0] rdata;
        logic [3:0] led_drive;
    } bank_t;

    bank_t s_q; // Registered state
    bank_t s_d; // Next state

    logic flash_phase; // Shared 1 Hz phase
    logic requested_on; // Pin and bit enable
    logic forced; // Override active
    logic any_log; // Any log bit set
    logic restart; // Enable went away
    access_t acc; // Decoded access kind

    // Shared flash divider
    flash_clock_gen #(
        .HALF_CYCLES(FLASH_HALF_CYCLES)
    ) u_flash (
        .clk(clk),
        .rst(rst),
        .flash_phase(flash_phase)
    );

    // Read-clear mask for one log register
    function automatic logic [7:0] rc_update(input logic [7:0] cur, input logic [7:0] hits,
                                             input logic clr);
        logic [7:0] v;
        v = clr ? 8'h00 : cur;
        // Set wins over a clear in the same cycle
        rc_update = v | hits;
    endfunction : rc_update

    // Access decode and combinational helpers
    always_comb begin
        acc = acc_idle;
        if (reg_wr) begin
            acc = acc_write;
        end else if (reg_rd) begin
            acc = acc_read;
        end
        requested_on = channel_on_pin & channel_enable_first & channel_enable_second;
        forced = s_q.override_bit && (s_q.force_on_unlock_key == `FO_KEY_VALUE);
        restart = !requested_on && !forced;
        any_log = |{s_q.breaker_event_log, s_q.undervoltage_event_status,
                    s_q.overvoltage_event_status, s_q.overcurrent_warning_status};
    end

    // Next-state logic
    always_comb begin
        logic [7:0] uv_hits;
        logic [7:0] ov_hits;
        logic [7:0] oc_hits;
        logic [7:0] br_hits;
        logic rd_clr;
        logic crit_trip;
        logic brk_trip;
        logic enabled_now;
        uv_hits = 8'h00;
        ov_hits = 8'h00;
        oc_hits = 8'h00;
        br_hits = 8'h00;
        // Locals start defined on every pass
        rd_clr = 1'b0;
        crit_trip = 1'b0;
        brk_trip = 1'b0;
        enabled_now = 1'b0;
        s_d = s_q;
        enabled_now = forced || (requested_on && !s_q.latched_off);
        // warn bit 0, crit bit 4
        uv_hits[`BIT_WARN] = uv_warn_hit;
        uv_hits[`BIT_CRIT] = uv_crit_hit;
        ov_hits[`BIT_WARN] = ov_warn_hit;
        ov_hits[`BIT_CRIT] = ov_crit_hit;
        oc_hits[`BIT_WARN] = oc_warn_hit;
        br_hits[`BIT_SLOW] = slow_trip_hit && enabled_now;
        br_hits[`BIT_FAST] = fast_trip_hit && enabled_now;
        rd_clr = (acc == acc_read);
        s_d.undervoltage_event_status = rc_update(s_q.undervoltage_event_status, uv_hits,
            (rd_clr && reg_addr == `ADDR_UV_STATUS) || restart);
        s_d.overvoltage_event_status = rc_update(s_q.overvoltage_event_status, ov_hits,
            (rd_clr && reg_addr == `ADDR_OV_STATUS) || restart);
        s_d.overcurrent_warning_status = rc_update(s_q.overcurrent_warning_status, oc_hits,
            (rd_clr && reg_addr == `ADDR_OC_STATUS) || restart);
        // Breaker log is read-only, cleared only by restart
        s_d.breaker_event_log = rc_update(s_q.breaker_event_log, br_hits, restart);
        brk_trip = br_hits[`BIT_SLOW] | br_hits[`BIT_FAST];
        crit_trip = crit_shutdown_en && (uv_crit_hit || ov_crit_hit) && enabled_now;
        if (restart) begin
            s_d.latched_off = 1'b0;
            s_d.breaker_shutdown = 1'b0;
        end else if (!forced && (brk_trip || crit_trip)) begin
            s_d.latched_off = 1'b1;
            if (brk_trip) begin
                s_d.breaker_shutdown = 1'b1;
            end
        end
        s_d.enable_seen = enabled_now;
        // Register writes
        if (acc == acc_write) begin
            case (reg_addr)
                `ADDR_FO_KEY: s_d.force_on_unlock_key = reg_wdata;
                `ADDR_FO_CTRL: begin
                    if (s_q.force_on_unlock_key == `FO_KEY_VALUE) begin
                        s_d.override_bit = reg_wdata[`BIT_FO];
                    end
                end
                `ADDR_FLASH_ENABLE_BIT: s_d.led_drive_flash_control = reg_wdata;
                `ADDR_LED_PHASE: s_d.led_phase_pullup_control = reg_wdata;
                default: begin
                    // Read-only or unmapped: ignored
                end
            endcase
        end
        s_d.pin_level_readback = led_i;
        for (int i = 0; i < 4; i++) begin
            if (s_q.led_drive_flash_control[4 + i]) begin
                s_d.led_drive[i] = flash_phase ^ s_q.led_phase_pullup_control[4 + i];
            end else begin
                s_d.led_drive[i] = ~s_q.led_drive_flash_control[i];
            end
        end
        // Read data, registered
        s_d.rdata = 8'h00;
        case (reg_addr)
            `ADDR_BREAKER_EVENT: s_d.rdata = s_q.breaker_event_log;
            `ADDR_UV_STATUS: s_d.rdata = s_q.undervoltage_event_status;
            `ADDR_OV_STATUS: s_d.rdata = s_q.overvoltage_event_status;
            `ADDR_OC_STATUS: s_d.rdata = s_q.overcurrent_warning_status;
            `ADDR_FO_KEY: s_d.rdata = s_q.force_on_unlock_key;
            `ADDR_FO_CTRL: s_d.rdata = {7'h00, s_q.override_bit};
            `ADDR_FLASH_ENABLE_BIT: s_d.rdata = s_q.led_drive_flash_control;
            `ADDR_LED_PHASE: s_d.rdata = s_q.led_phase_pullup_control;
            `ADDR_PIN_LEVEL: s_d.rdata = {4'h0, s_q.pin_level_readback};
            `ADDR_GEN_STATUS: s_d.rdata = {3'h0, any_log, 4'h0};
            default: s_d.rdata = 8'h00;
        endcase
    end

    // Register all state
    always_ff @(posedge clk) begin
        if (rst) begin
            s_q <= '0;
            s_q.led_drive_flash_control <= `RST_FLASH_ENABLE_BIT;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs
    assign reg_rdata = s_q.rdata;
    assign channel_enable = s_q.enable_seen;
    // Open drain: output always low, enable pulls
    assign fault_n_o = 1'b0;
    assign fault_n_oe = s_q.breaker_shutdown;
    assign alert_n_o = 1'b0;
    assign alert_n_oe = any_log;
    assign led_o = '0;
    assign led_oe = s_q.led_drive;
    assign led_pullup_en = s_q.led_phase_pullup_control[3:0];
endmodule : hotswap_fault_led_control

// ===== hw/hotswap_fault_consts.svh
// Constants for the hot-swap fault and indicator register bank.
// Assumes an 8-bit register port supplied by the serial front end.
`ifndef HOTSWAP_FAULT_CONSTS_SVH
`define HOTSWAP_FAULT_CONSTS_SVH
// Register offsets
`define ADDR_BREAKER_EVENT 8'h31
`define ADDR_UV_STATUS 8'h35
`define ADDR_OV_STATUS 8'h36
`define ADDR_OC_STATUS 8'h37
`define ADDR_FO_KEY 8'h39
`define ADDR_FO_CTRL 8'h3a
`define ADDR_FLASH_ENABLE_BIT 8'h43
`define ADDR_LED_PHASE 8'h44
`define ADDR_PIN_LEVEL 8'h45
`define ADDR_GEN_STATUS 8'h3c
// Reset values
`define RST_FLASH_ENABLE_BIT 8'h0f
`define RST_ZERO 8'h00
// Unlock key value
`define FO_KEY_VALUE 8'ha5
// Field positions
`define BIT_WARN 0
`define BIT_CRIT 4
`define BIT_FAST 0
`define BIT_SLOW 2
`define BIT_ALERT 4
`define BIT_FO 0
// Flash timing: half period of the 1 Hz flash clock
`define FLASH_HALF_MS 500
`define CLK_MHZ 250
`define FLASH_HALF_CYC (`FLASH_HALF_MS * 1000 * `CLK_MHZ)
`endif

// ===== hw/hotswap_fault_pkg.sv
// Types for the hot-swap fault and indicator register bank.
// Assumes the constants header is included by each user.
package hotswap_fault_pkg;
    // Register data byte
    typedef logic [7:0] reg_byte_t;
    // Register port access kind, one-hot
    typedef enum logic [2:0] {
        acc_idle = 3'h1,
        acc_read = 3'h2,
        acc_write = 3'h4
    } access_t;
endpackage : hotswap_fault_pkg

// ===== hw/flash_clock_gen.sv
// Divider that makes the shared 1 Hz flash clock from the system clock.
// Assumes clk runs at the documented rate; the count is a parameter.
`timescale 1ns/1ns
`include "hotswap_fault_consts.svh"
module flash_clock_gen #(
    parameter int unsigned HALF_CYCLES = `FLASH_HALF_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Shared flash phase
    output logic flash_phase
);
    import hotswap_fault_pkg::*;

    // State of the divider
    typedef struct packed {
        logic [31:0] count;
        logic phase;
    } div_state_t;

    div_state_t s_q; // Registered state
    div_state_t s_d; // Next state

    // A zero half period would wrap the compare and toggle only every 2^32 cycles
    initial begin
        if (HALF_CYCLES < 1) begin
            $error("flash_clock_gen: HALF_CYCLES must be at least 1");
        end
    end

    always_comb begin
        s_d = s_q;
        if (s_q.count >= HALF_CYCLES - 1) begin
            s_d.count = 32'h0;
            s_d.phase = ~s_q.phase;
        end else begin
            s_d.count = s_q.count + 32'h1;
        end
    end

    // Register the divider
    always_ff @(posedge clk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign flash_phase = s_q.phase;
endmodule : flash_clock_gen

// ===== dv/hotswap_fault_monitor.sv
// Checker on the ports of the fault and indicator register bank.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ns
`include "hotswap_fault_consts.svh"
module hotswap_fault_monitor #(
    parameter int unsigned NUM_LEDS = 4,
    parameter int unsigned FLASH_HALF_CYCLES = 4
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire hotswap_fault_pkg::reg_byte_t reg_addr,
    input wire hotswap_fault_pkg::reg_byte_t reg_wdata,
    input wire hotswap_fault_pkg::reg_byte_t reg_rdata,
    // Channel, hits and fault pins
    input wire logic channel_on_pin,
    input wire logic channel_enable_first,
    input wire logic channel_enable_second,
    input wire logic uv_warn_hit,
    input wire logic uv_crit_hit,
    input wire logic slow_trip_hit,
    input wire logic fast_trip_hit,
    input wire logic channel_enable,
    input wire logic fault_n_oe,
    input wire logic alert_n_oe,
    // LED pins
    input wire logic [NUM_LEDS-1:0] led_oe,
    input wire logic [NUM_LEDS-1:0] led_pullup_en
);
    import hotswap_fault_pkg::*;
    // Enable request, all three sources high
    logic req;
    assign req = channel_on_pin & channel_enable_first & channel_enable_second;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    alert_set_a: assert property (uv_warn_hit && req |=> alert_n_oe)
        else $error("alert not raised");
    fault_cause_a: assert property ($rose(fault_n_oe) |-> $past(slow_trip_hit || fast_trip_hit))
        else $error("fault without trip");
    fault_shut_a: assert property ($rose(fault_n_oe) |=> !channel_enable)
        else $error("channel kept on after trip");
    fault_release_a: assert property (!req |=> !fault_n_oe)
        else $error("fault not released");
    status_mirror_a: assert property (reg_addr == `ADDR_GEN_STATUS |=> reg_rdata[`BIT_ALERT] == $past(alert_n_oe))
        else $error("alert mirror wrong");
    pullup_write_a: assert property (reg_wr && reg_addr == `ADDR_LED_PHASE
        |-> ##2 led_pullup_en == $past(reg_wdata[NUM_LEDS-1:0], 2)) else $error("pull-up mismatch");
    led_off_a: assert property (reg_wr && reg_addr == `ADDR_FLASH_ENABLE_BIT && reg_wdata[7:4] == 4'h0
        |-> ##2 led_oe == ~$past(reg_wdata[NUM_LEDS-1:0], 2)) else $error("led drive mismatch");
    read_clear_a: assert property (reg_rd && reg_addr == `ADDR_UV_STATUS && !uv_warn_hit && !uv_crit_hit
        ##1 reg_addr == `ADDR_UV_STATUS && !uv_warn_hit && !uv_crit_hit |=> reg_rdata == 8'h00)
        else $error("status not cleared by read");
    // Main scenarios
    cover property ($rose(fault_n_oe));
    cover property ($rose(alert_n_oe));
    cover property (reg_wr && reg_addr == `ADDR_FO_CTRL);
endmodule : hotswap_fault_monitor
bind hotswap_fault_led_control hotswap_fault_monitor #(.NUM_LEDS(NUM_LEDS), .FLASH_HALF_CYCLES(FLASH_HALF_CYCLES))
    u_hotswap_fault_monitor (.clk, .rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .channel_on_pin,
    .channel_enable_first, .channel_enable_second, .uv_warn_hit, .uv_crit_hit, .slow_trip_hit, .fast_trip_hit,
    .channel_enable, .fault_n_oe, .alert_n_oe, .led_oe, .led_pullup_en);

// ===== dv/host_model.sv
// Host model issuing single-byte register reads and writes.
// Assumes read data is registered one cycle after the address.
`timescale 1ns/1ns
module host_model (
    // Clock
    input wire logic clk,
    // Register port
    output logic reg_wr,
    output logic reg_rd,
    output hotswap_fault_pkg::reg_byte_t reg_addr,
    output hotswap_fault_pkg::reg_byte_t reg_wdata,
    input wire hotswap_fault_pkg::reg_byte_t reg_rdata
);
    import hotswap_fault_pkg::*;
    // Idle port at time zero
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end
    // Write; data inverted once taken so stale data is never reused
    task automatic wr(input reg_byte_t a, input reg_byte_t d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_wdata <= ~d;
    endtask : wr
    task automatic rd(input reg_byte_t a, output reg_byte_t d);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd
endmodule : host_model

// ===== dv/tb.sv
// Self-checking bench for the fault and indicator register bank.
// Assumes host_model and the bound checker are compiled before it.
`timescale 1ns/1ns
`include "hotswap_fault_consts.svh"
module tb;
    import hotswap_fault_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic reg_wr, reg_rd, on_pin = 1'b1, en_a = 1'b1, en_b = 1'b1, crit_en = 1'b0;
    reg_byte_t reg_addr, reg_wdata, reg_rdata, d;
    // Hits: uv warn, uv crit, ov warn, ov crit, oc warn; trips: fast, slow
    logic [4:0] hit = 5'h00;
    logic [1:0] trip = 2'h0;
    logic [3:0] led_in = 4'h0, led_oe, pull_en;
    logic channel_enable, fault_n_oe, alert_n_oe;
    // Open-drain data levels, expected always low
    logic fault_n_o, alert_n_o;
    logic [3:0] led_o;
    int fail_count = 0;
    int num_checks = 0;
    reg_byte_t ra[9] = '{8'h31, 8'h35, 8'h36, 8'h37, 8'h39, 8'h3a, 8'h43, 8'h44, 8'h50};
    reg_byte_t ha[5] = '{8'h35, 8'h35, 8'h36, 8'h36, 8'h37};
    reg_byte_t hb[5] = '{8'h01, 8'h10, 8'h01, 8'h10, 8'h01};
    // 250 MHz clock
    always #2 clk = ~clk;
    hotswap_fault_led_control #(.NUM_LEDS(4), .FLASH_HALF_CYCLES(4)) u_hotswap_fault_led_control (
        .clk, .rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .channel_on_pin(on_pin),
        .channel_enable_first(en_a), .channel_enable_second(en_b), .uv_warn_hit(hit[0]), .uv_crit_hit(hit[1]),
        .ov_warn_hit(hit[2]), .ov_crit_hit(hit[3]), .oc_warn_hit(hit[4]), .slow_trip_hit(trip[1]),
        .fast_trip_hit(trip[0]), .crit_shutdown_en(crit_en), .channel_enable, .fault_n_o, .fault_n_oe,
        .alert_n_o, .alert_n_oe, .led_i(led_in), .led_o, .led_oe, .led_pullup_en(pull_en));
    host_model u_host_model (.clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata);
    // Compare and count
    task automatic chk(input reg_byte_t got, input reg_byte_t exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t ns: got %h, expected %h", $time, got, exp);
        end
    endtask : chk
    // Read one register and compare
    task automatic rdc(input reg_byte_t a, input reg_byte_t exp);
        reg_byte_t v;
        u_host_model.rd(a, v);
        chk(v, exp);
    endtask : rdc
    // Let edges pass, then step off the edge
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc
    // One-cycle pulse of hits and trips
    task automatic pulse(input logic [4:0] h, input logic [1:0] t);
        @(posedge clk);
        hit <= h;
        trip <= t;
        @(posedge clk);
        hit <= 5'h00;
        trip <= 2'h0;
        cyc(2);
    endtask : pulse
    // restart by dropping pin or bit
    task automatic restart(input bit by_bit);
        @(posedge clk);
        on_pin <= by_bit;
        en_a <= !by_bit;
        cyc(2);
        chk({7'h00, fault_n_oe}, 8'h00);
        @(posedge clk);
        on_pin <= 1'b1;
        en_a <= 1'b1;
        cyc(3);
    endtask : restart
    // Verdict and end of run
    task automatic end_sim;
        $display("Checks %0d, errors %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_sim
    // Run needs under two hundred cycles; this limit means a hang
    initial begin
        repeat (5000) @(posedge clk);
        fail_count++;
        end_sim();
    end
    initial begin
        logic [7:0] tog, same;
        logic prev;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        // Reset values; the last address is unmapped
        foreach (ra[i]) begin
            rdc(ra[i], (ra[i] == `ADDR_FLASH_ENABLE_BIT) ? `RST_FLASH_ENABLE_BIT : `RST_ZERO);
        end
        chk({led_oe, 3'h0, channel_enable}, 8'h01);
        chk({2'h0, fault_n_o, alert_n_o, led_o}, 8'h00);
        u_host_model.wr(`ADDR_BREAKER_EVENT, 8'hff);
        rdc(`ADDR_BREAKER_EVENT, 8'h00);
        for (int i = 0; i < 5; i++) begin
            pulse(5'(1 << i), 2'h0);
            chk({7'h00, alert_n_oe}, 8'h01);
            u_host_model.rd(`ADDR_GEN_STATUS, d);
            chk(d & 8'h10, 8'h10);
            rdc(ha[i], hb[i]);
            rdc(ha[i], 8'h00);
            chk({7'h00, alert_n_oe}, 8'h00);
        end
        pulse(5'h00, 2'h1);
        chk({6'h00, fault_n_oe, channel_enable}, 8'h02);
        rdc(`ADDR_BREAKER_EVENT, 8'h01);
        rdc(`ADDR_BREAKER_EVENT, 8'h01);
        restart(1'b0);
        rdc(`ADDR_BREAKER_EVENT, 8'h00);
        pulse(5'h00, 2'h2);
        chk({6'h00, fault_n_oe, channel_enable}, 8'h02);
        rdc(`ADDR_BREAKER_EVENT, 8'h04);
        restart(1'b1);
        @(posedge clk);
        crit_en <= 1'b1;
        pulse(5'h08, 2'h0);
        chk({6'h00, fault_n_oe, channel_enable}, 8'h00);
        restart(1'b0);
        @(posedge clk);
        crit_en <= 1'b0;
        on_pin <= 1'b0;
        u_host_model.wr(`ADDR_FO_KEY, 8'h5a);
        u_host_model.wr(`ADDR_FO_CTRL, 8'h01);
        cyc(3);
        chk({7'h00, channel_enable}, 8'h00);
        rdc(`ADDR_FO_CTRL, 8'h00);
        u_host_model.wr(`ADDR_FO_KEY, `FO_KEY_VALUE);
        u_host_model.wr(`ADDR_FO_CTRL, 8'h01);
        cyc(3);
        chk({7'h00, channel_enable}, 8'h01);
        pulse(5'h00, 2'h1);
        chk({fault_n_oe, alert_n_oe, channel_enable}, 8'h03);
        rdc(`ADDR_BREAKER_EVENT, 8'h01);
        u_host_model.wr(`ADDR_FO_CTRL, 8'h00);
        cyc(3);
        chk({7'h00, channel_enable}, 8'h00);
        @(posedge clk);
        on_pin <= 1'b1;
        u_host_model.wr(`ADDR_FLASH_ENABLE_BIT, 8'h05);
        u_host_model.wr(`ADDR_LED_PHASE, 8'h0a);
        cyc(2);
        chk({led_oe, pull_en}, 8'haa);
        u_host_model.wr(`ADDR_LED_PHASE, 8'h20);
        u_host_model.wr(`ADDR_FLASH_ENABLE_BIT, 8'h30);
        cyc(4);
        tog = 8'h00;
        same = 8'h00;
        prev = led_oe[0];
        for (int i = 0; i < 16; i++) begin
            cyc(1);
            if (led_oe[0] !== prev) tog++;
            if (led_oe[0] === led_oe[1]) same++;
            prev = led_oe[0];
        end
        chk(tog, 8'h04);
        chk({same[6:0], led_oe[2]}, 8'h01);
        @(posedge clk);
        led_in <= 4'h9;
        cyc(4);
        u_host_model.rd(`ADDR_PIN_LEVEL, d);
        chk(d & 8'h0f, 8'h09);
        end_sim();
    end
endmodule : tb
